// ==== hw/ppss_pkg.sv ====
package ppss_pkg;

	////////////////////////////////////////////////////////////////////////////
	// object indices
	localparam logic [15:0] IDX_FAULT_CODE     = 16'h603F;
	localparam logic [15:0] IDX_STATE_WORD     = 16'h6041;
	localparam logic [15:0] IDX_MODE_DISPLAY   = 16'h6061;
	localparam logic [15:0] IDX_CMD_POS        = 16'h6062;
	localparam logic [15:0] IDX_MEAS_POS_RAW   = 16'h6063;
	localparam logic [15:0] IDX_MEAS_POS       = 16'h6064;
	localparam logic [15:0] IDX_DEV_LIMIT      = 16'h6065;
	localparam logic [15:0] IDX_ARRIVAL_WINDOW = 16'h6067;
	localparam logic [15:0] IDX_ARRIVAL_DWELL  = 16'h6068;
	localparam logic [15:0] IDX_MEAS_SPEED     = 16'h606C;
	localparam logic [15:0] IDX_MEAS_TORQUE    = 16'h6077;
	localparam logic [15:0] IDX_SPEED_CEILING  = 16'h607F;
	localparam logic [15:0] IDX_TRACKING_ERR   = 16'h60F4;
	localparam logic [15:0] IDX_CMD_POS_RAW    = 16'h60FC;
	localparam logic [15:0] IDX_WINDOW_UNIT    = 16'h2013;

	////////////////////////////////////////////////////////////////////////////
	// control and status word bit positions
	localparam int CW_NEW_SP     = 4;
	localparam int CW_IMMEDIATE  = 5;
	localparam int CW_RELATIVE   = 6;
	localparam int SW_ARRIVED    = 10;
	localparam int SW_ACK        = 12;
	localparam int SW_FOLLOW_ERR = 13;
	localparam int SW_HOMED      = 15;
	localparam logic [15:0] SW_OWN_MASK = 16'hB400;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [31:0] RST_DEV_LIMIT = 32'h0000_0000;
	localparam logic [15:0] RST_WINDOW    = 16'h0000;
	localparam logic [15:0] RST_DWELL     = 16'h0000;
	localparam logic [31:0] RST_CEILING   = 32'h0000_0000;
	localparam logic        RST_UNIT_ENC  = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// timing: dwell time counts in milliseconds
	localparam int DWELL_UNIT_NS = 1000000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_CYCLES     = DWELL_UNIT_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_MOVE  = 2'b01,
		ST_QUEUE = 2'b11
	} ppss_mode_e;

	typedef struct packed {
		ppss_mode_e  st;
		logic        bit4Prev;
		logic        ack;
		logic        arrived;
		logic        devAlarm;
		logic        homed;
		logic        moveStart;
		logic        unitEnc;
		logic [15:0] baseStatus;
		logic [31:0] moveTarget;
		logic [31:0] queuedTarget;
		logic [31:0] devLimit;
		logic [15:0] window;
		logic [15:0] dwellTime;
		logic [31:0] ceiling;
		logic [31:0] speedLimit;
		logic [16:0] msCnt;
		logic [15:0] dwellCnt;
		logic [31:0] rdata;
	} ppss_state_s;

endpackage : ppss_pkg

// ==== hw/ppss_setpoint_status.sv ====
// Behaviour
// - status bit 10 high when target reached or quick stop finished, low otherwise
// - status bit 12 is the set-point acknowledge flag
// - status bit 13 high while following error is excessive
// - status bit 15 follows homingDone: high while it is high, low again when it drops
// - quick stop finished sets bit 10 unless a move starts in the same cycle
// - completion needs difference inside window for dwellTime ticks of the free-running ms counter
// - window compared in command units (0) or encoder units (1)
// - alarm when target-actual difference exceeds unsigned 32-bit limit
// - speed limit is smaller of ceiling and motor maximum speed
// - bit 4 rising edge latches target, starts if idle, sets ack
// - ack clears after bit 4 low, unless a set-point is queued
// - non-immediate: set-point during move is stored and acked, no start
// - non-immediate: move finished, ack cleared and stored set-point started
// - read-only monitor objects exposed through the object port
// - bit 5 high abandons current move and starts new set-point
// - bit 6 selects absolute or relative target
`timescale 1ns/1ns
module ppss_setpoint_status
	import ppss_pkg::*;
#(
	parameter int MS_CYC = MS_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic [15:0] ctrlWord,
	input  wire logic [31:0] targetPos,
	input  wire logic [15:0] baseStatus,
	input  wire logic        homingDone,
	input  wire logic        quickStopDone,
	input  wire logic        motionIdle,
	input  wire logic [31:0] motorMaxSpeed,
	input  wire logic [15:0] faultCode,
	input  wire logic [7:0]  modeDisplay,
	input  wire logic [31:0] actualPos,
	input  wire logic [31:0] actualPosEnc,
	input  wire logic [31:0] demandPosEnc,
	input  wire logic [31:0] actualSpeed,
	input  wire logic [15:0] actualTorque,
	input  wire logic [15:0] objIndex,
	input  wire logic        objWr,
	input  wire logic [31:0] objWdata,
	output logic      [31:0] objRdata,
	output logic      [15:0] statusWord,
	output logic             moveStart,
	output logic      [31:0] moveTarget,
	output logic      [31:0] speedLimit,
	output logic             posComplete,
	output logic             devAlarm
);

	////////////////////////////////////////////////////////////////////////////
	// state
	localparam logic [16:0] MS_LAST = 17'(MS_CYC - 1);

	ppss_state_s cur;
	ppss_state_s nxt;

	logic        newSp;
	logic        immediate;
	logic [31:0] reqTarget;
	logic [32:0] diffCmd;
	logic [32:0] diffEnc;
	logic [32:0] absCmd;
	logic [32:0] absEnc;
	logic [32:0] absWin;
	logic        inWindow;
	logic        devExceeded;
	logic        msTick;
	logic [31:0] readMux;

	////////////////////////////////////////////////////////////////////////////
	// combinational helpers
	assign newSp     = ctrlWord[CW_NEW_SP] && !cur.bit4Prev;
	assign immediate = ctrlWord[CW_IMMEDIATE];
	assign reqTarget = ctrlWord[CW_RELATIVE] ? targetPos + actualPos : targetPos;

	assign diffCmd = {cur.moveTarget[31], cur.moveTarget} - {actualPos[31], actualPos};
	assign diffEnc = {demandPosEnc[31], demandPosEnc} - {actualPosEnc[31], actualPosEnc};
	assign absCmd  = diffCmd[32] ? 33'h0 - diffCmd : diffCmd;
	assign absEnc  = diffEnc[32] ? 33'h0 - diffEnc : diffEnc;
	assign absWin  = cur.unitEnc ? absEnc : absCmd;

	assign inWindow    = absWin <= {17'h00000, cur.window};
	assign devExceeded = absCmd > {1'b0, cur.devLimit};
	assign msTick      = cur.msCnt == MS_LAST;

	function automatic ppss_state_s startMove(input ppss_state_s s, input logic [31:0] t);
		ppss_state_s r;
		r            = s;
		r.moveTarget = t;
		r.moveStart  = 1'b1;
		r.st         = ST_MOVE;
		r.arrived    = 1'b0;
		r.dwellCnt   = 16'h0000;
		return r;
	endfunction : startMove

	always_comb begin
		unique case (objIndex)
			IDX_FAULT_CODE:     readMux = {16'h0000, faultCode};
			IDX_STATE_WORD:     readMux = {16'h0000, statusWord};
			IDX_MODE_DISPLAY:   readMux = {24'h000000, modeDisplay};
			IDX_CMD_POS:        readMux = cur.moveTarget;
			IDX_MEAS_POS_RAW:   readMux = actualPosEnc;
			IDX_MEAS_POS:       readMux = actualPos;
			IDX_DEV_LIMIT:      readMux = cur.devLimit;
			IDX_ARRIVAL_WINDOW: readMux = {16'h0000, cur.window};
			IDX_ARRIVAL_DWELL:  readMux = {16'h0000, cur.dwellTime};
			IDX_MEAS_SPEED:     readMux = actualSpeed;
			IDX_MEAS_TORQUE:    readMux = {16'h0000, actualTorque};
			IDX_SPEED_CEILING:  readMux = cur.ceiling;
			IDX_TRACKING_ERR:   readMux = diffCmd[31:0];
			IDX_CMD_POS_RAW:    readMux = demandPosEnc;
			IDX_WINDOW_UNIT:    readMux = {31'h00000000, cur.unitEnc};
			default:            readMux = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		nxt            = cur;
		nxt.moveStart  = 1'b0;
		nxt.bit4Prev   = ctrlWord[CW_NEW_SP];
		nxt.homed      = homingDone;
		nxt.baseStatus = baseStatus & ~SW_OWN_MASK;
		nxt.devAlarm   = devExceeded;
		nxt.speedLimit = (cur.ceiling < motorMaxSpeed) ? cur.ceiling : motorMaxSpeed;
		nxt.rdata      = readMux;
		nxt.msCnt      = msTick ? 17'h00000 : cur.msCnt + 17'h00001;

		if (!inWindow) begin
			nxt.dwellCnt = 16'h0000;
		end else if (msTick && cur.dwellCnt != 16'hFFFF) begin
			nxt.dwellCnt = cur.dwellCnt + 16'h0001;
		end
		nxt.arrived = (inWindow && cur.dwellCnt >= cur.dwellTime) || quickStopDone;

		if (cur.ack && !ctrlWord[CW_NEW_SP] && cur.st != ST_QUEUE) begin
			nxt.ack = 1'b0;
		end

		unique case (cur.st)
			ST_IDLE, ST_MOVE: begin
				if (newSp) begin
					nxt.ack = 1'b1;
					if (cur.st == ST_IDLE || immediate) begin
						nxt = startMove(nxt, reqTarget);
					end else begin
						nxt.queuedTarget = reqTarget;
						nxt.st           = ST_QUEUE;
					end
				end else if (cur.st == ST_MOVE && motionIdle && !cur.moveStart) begin
					nxt.st = ST_IDLE;
				end
			end
			ST_QUEUE: begin
				if (newSp) begin
					nxt.ack = 1'b1;
					if (immediate) begin
						nxt = startMove(nxt, reqTarget);
					end else begin
						nxt.queuedTarget = reqTarget;
					end
				end else if (motionIdle) begin
					nxt     = startMove(nxt, cur.queuedTarget);
					nxt.ack = 1'b0;
				end
			end
			default: begin
				nxt.st = ST_IDLE;
			end
		endcase

		if (objWr) begin
			unique case (objIndex)
				IDX_DEV_LIMIT:      nxt.devLimit  = objWdata;
				IDX_ARRIVAL_WINDOW: nxt.window    = objWdata[15:0];
				IDX_ARRIVAL_DWELL:  nxt.dwellTime = objWdata[15:0];
				IDX_SPEED_CEILING:  nxt.ceiling   = objWdata;
				IDX_WINDOW_UNIT:    nxt.unitEnc   = objWdata[0];
				default:            nxt.ceiling   = nxt.ceiling;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cur.st           <= ST_IDLE;
			cur.bit4Prev     <= 1'b0;
			cur.ack          <= 1'b0;
			cur.arrived      <= 1'b0;
			cur.devAlarm     <= 1'b0;
			cur.homed        <= 1'b0;
			cur.moveStart    <= 1'b0;
			cur.unitEnc      <= RST_UNIT_ENC;
			cur.baseStatus   <= 16'h0000;
			cur.moveTarget   <= 32'h0000_0000;
			cur.queuedTarget <= 32'h0000_0000;
			cur.devLimit     <= RST_DEV_LIMIT;
			cur.window       <= RST_WINDOW;
			cur.dwellTime    <= RST_DWELL;
			cur.ceiling      <= RST_CEILING;
			cur.speedLimit   <= 32'h0000_0000;
			cur.msCnt        <= 17'h00000;
			cur.dwellCnt     <= 16'h0000;
			cur.rdata        <= 32'h0000_0000;
		end else begin
			cur <= nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	always_comb begin
		statusWord                = cur.baseStatus;
		statusWord[SW_ARRIVED]    = cur.arrived;
		statusWord[SW_ACK]        = cur.ack;
		statusWord[SW_FOLLOW_ERR] = cur.devAlarm;
		statusWord[SW_HOMED]      = cur.homed;
	end

	assign objRdata    = cur.rdata;
	assign moveStart   = cur.moveStart;
	assign moveTarget  = cur.moveTarget;
	assign speedLimit  = cur.speedLimit;
	assign posComplete = cur.arrived;
	assign devAlarm    = cur.devAlarm;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence newSpIdle;
		newSp && cur.st == ST_IDLE;
	endsequence

	sequence newSpQueued;
		newSp && cur.st == ST_MOVE && !immediate;
	endsequence

	sequence queueRelease;
		cur.st == ST_QUEUE && !newSp && motionIdle;
	endsequence

	ack_set_a: assert property (newSp |=> statusWord[SW_ACK])
		else $error("ack not raised after new set-point");

	ack_clear_a: assert property (
		statusWord[SW_ACK] && !ctrlWord[CW_NEW_SP] && cur.st != ST_QUEUE
		|=> !statusWord[SW_ACK])
		else $error("ack not cleared after bit 4 low");

	idle_start_a: assert property (newSpIdle |=> moveStart
		&& moveTarget == $past(reqTarget) && !posComplete)
		else $error("idle set-point did not start");

	queue_hold_a: assert property (newSpQueued |=> !moveStart && cur.st == ST_QUEUE
		##1 (statusWord[SW_ACK] || cur.st != ST_QUEUE))
		else $error("queued set-point started or lost ack");

	queue_start_a: assert property (queueRelease |=> moveStart && !statusWord[SW_ACK]
		&& moveTarget == $past(cur.queuedTarget))
		else $error("queued set-point not started");

	immed_start_a: assert property (newSp && immediate |=> moveStart
		&& moveTarget == $past(reqTarget))
		else $error("immediate set-point not started");

	rel_target_a: assert property (newSpIdle and ctrlWord[CW_RELATIVE]
		|=> moveTarget == $past(targetPos) + $past(actualPos))
		else $error("relative target wrong");

	start_clear_a: assert property (moveStart |-> !statusWord[SW_ARRIVED])
		else $error("arrived set while starting");

	arrive_cause_a: assert property ($rose(posComplete) |->
		$past(quickStopDone) || ($past(inWindow) && $past(cur.dwellCnt) >= $past(cur.dwellTime)))
		else $error("arrived without dwell");

	dwell_reset_a: assert property (!inWindow |=> cur.dwellCnt == 16'h0000)
		else $error("dwell timer not restarted");

	qstop_arrive_a: assert property (quickStopDone && !nxt.moveStart |=> posComplete)
		else $error("quick stop did not set arrived");

	dev_alarm_a: assert property (devExceeded |=> devAlarm && statusWord[SW_FOLLOW_ERR])
		else $error("deviation alarm missing");

	speed_lim_a: assert property (##1 speedLimit <= $past(cur.ceiling)
		&& speedLimit <= $past(motorMaxSpeed))
		else $error("speed limit above a bound");

	homed_bit_a: assert property (##1 statusWord[SW_HOMED] == $past(homingDone))
		else $error("homed bit mismatch");

	sequence queueWait;
		cur.st == ST_QUEUE && !motionIdle && !(newSp && immediate);
	endsequence

	arrive_drop_a: assert property (!inWindow && !quickStopDone |=> !posComplete)
		else $error("arrived held outside window");

	ack_only_a: assert property (!statusWord[SW_ACK] && !newSp |=> !statusWord[SW_ACK])
		else $error("ack raised without new set-point");

	follow_clear_a: assert property (!devExceeded |=> !statusWord[SW_FOLLOW_ERR])
		else $error("following error bit stuck");

	dev_clear_a: assert property (!devExceeded |=> !devAlarm)
		else $error("deviation alarm without cause");

	dwell_wait_a: assert property (inWindow && cur.dwellCnt < cur.dwellTime
		&& !quickStopDone |=> !posComplete)
		else $error("arrived before dwell elapsed");

	window_cmd_a: assert property (!cur.unitEnc && absCmd > {17'h00000, cur.window}
		&& !quickStopDone |=> !posComplete)
		else $error("command unit window ignored");

	window_enc_a: assert property (cur.unitEnc && absEnc > {17'h00000, cur.window}
		&& !quickStopDone |=> !posComplete)
		else $error("encoder unit window ignored");

	ack_keep_a: assert property (statusWord[SW_ACK] && ctrlWord[CW_NEW_SP]
		&& cur.st != ST_QUEUE |=> statusWord[SW_ACK])
		else $error("ack dropped while bit 4 high");

	queue_keep_a: assert property (queueWait |=> statusWord[SW_ACK]
		&& !moveStart && cur.st == ST_QUEUE)
		else $error("queued set-point left early");

	queue_over_a: assert property (newSp && cur.st == ST_QUEUE && !immediate
		|=> cur.queuedTarget == $past(reqTarget))
		else $error("queued target not replaced");

	read_state_a: assert property (objIndex == IDX_STATE_WORD
		|=> objRdata == {16'h0000, $past(statusWord)})
		else $error("status word read wrong");

endmodule : ppss_setpoint_status

// ==== test/ppss_master_model.sv ====
`timescale 1ns/1ns
module ppss_master_model
	import ppss_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        go,
	input  wire logic        ackSeen,
	input  wire logic [31:0] newTarget,
	input  wire logic        imm,
	input  wire logic        rel,
	input  wire logic [1:0]  lag,
	output logic      [15:0] ctrlWord,
	output logic      [31:0] targetPos,
	output logic             busy
);
	int n;
	initial begin
		ctrlWord = 16'h0000;
		targetPos = 32'h0000_0000;
		busy = 1'b0;
		forever begin
			@(posedge ref_clk);
			if (go === 1'b1) begin
				#1;
				busy = 1'b1;
				targetPos = newTarget;
				ctrlWord[CW_IMMEDIATE] = imm;
				ctrlWord[CW_RELATIVE] = rel;
				@(posedge ref_clk);
				#1;
				ctrlWord[CW_NEW_SP] = 1'b1;
				n = 0;
				do begin
					@(posedge ref_clk);
					#1;
					n++;
				end while (ackSeen !== 1'b1 && n < 50);
				repeat (lag) begin
					@(posedge ref_clk);
					#1;
				end
				ctrlWord[CW_NEW_SP] = 1'b0;
				targetPos = ~targetPos;
				busy = 1'b0;
			end
		end
	end
endmodule : ppss_master_model

// ==== test/ppss_setpoint_status_tb_top.sv ====
`timescale 1ns/1ns
module ppss_setpoint_status_tb_top
	import ppss_pkg::*;
;
	localparam int MSC = 4;
	logic        ref_clk, sys_rst, homingDone, quickStopDone, motionIdle, objWr;
	logic        go, imm, rel, moveStart, posComplete, devAlarm, busy, cplAfter;
	logic [1:0]  lag;
	logic [7:0]  modeDisplay;
	logic [15:0] ctrlWord, baseStatus, faultCode, actualTorque, objIndex, statusWord;
	logic [31:0] targetPos, motorMaxSpeed, actualPos, actualPosEnc, demandPosEnc, actualSpeed;
	logic [31:0] objWdata, objRdata, moveTarget, speedLimit, newTarget, lastTgt, t, v;
	logic [15:0] rwIdx [4] = '{IDX_DEV_LIMIT, IDX_ARRIVAL_WINDOW, IDX_ARRIVAL_DWELL,
		IDX_SPEED_CEILING};
	int          errCount, comparisons, starts, n0;

	ppss_setpoint_status #(.MS_CYC(MSC)) ppss_setpoint_status_inst (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.ctrlWord      (ctrlWord),
		.targetPos     (targetPos),
		.baseStatus    (baseStatus),
		.homingDone    (homingDone),
		.quickStopDone (quickStopDone),
		.motionIdle    (motionIdle),
		.motorMaxSpeed (motorMaxSpeed),
		.faultCode     (faultCode),
		.modeDisplay   (modeDisplay),
		.actualPos     (actualPos),
		.actualPosEnc  (actualPosEnc),
		.demandPosEnc  (demandPosEnc),
		.actualSpeed   (actualSpeed),
		.actualTorque  (actualTorque),
		.objIndex      (objIndex),
		.objWr         (objWr),
		.objWdata      (objWdata),
		.objRdata      (objRdata),
		.statusWord    (statusWord),
		.moveStart     (moveStart),
		.moveTarget    (moveTarget),
		.speedLimit    (speedLimit),
		.posComplete   (posComplete),
		.devAlarm      (devAlarm)
	);
	ppss_master_model ppss_master_model_inst (
		.ref_clk   (ref_clk),
		.go        (go),
		.ackSeen   (statusWord[SW_ACK]),
		.newTarget (newTarget),
		.imm       (imm),
		.rel       (rel),
		.lag       (lag),
		.ctrlWord  (ctrlWord),
		.targetPos (targetPos),
		.busy      (busy)
	);

	////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		#1;
		if (moveStart === 1'b1) begin
			starts++;
			lastTgt = moveTarget;
			motionIdle = 1'b0;
			cplAfter = posComplete;
		end
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errCount++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", comparisons, errCount);
		if (errCount == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict

	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : tick

	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		objIndex = i;
		objWdata = d;
		objWr = 1'b1;
		tick(1);
	endtask : wr

	task automatic rdx(input logic [15:0] i, input logic [31:0] e, input string nm);
		objWr = 1'b0;
		objIndex = i;
		tick(1);
		chk(nm, objRdata, e);
	endtask : rdx

	task automatic sp(input logic [31:0] tg, input logic im, input logic rl, input logic ackExp);
		int n;
		newTarget = tg;
		imm = im;
		rel = rl;
		lag = 2'($urandom_range(3));
		go = 1'b1;
		tick(1);
		go = 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (busy !== 1'b0 && n < 60);
		#1;
		if (n >= 60) begin
			errCount++;
			print_verdict();
		end
		chk("hsLen", 32'(n < 12), 32'h1);
		chk("ack", 32'(statusWord[SW_ACK]), 32'(ackExp));
	endtask : sp

	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hEB5B62F4));
		sys_rst = 1'b1;
		motionIdle = 1'b1;
		{go, imm, rel, lag, newTarget, objIndex, objWr, objWdata, homingDone} = '0;
		{quickStopDone, motorMaxSpeed, faultCode, modeDisplay, actualPos} = '0;
		{actualPosEnc, demandPosEnc, actualSpeed, actualTorque, baseStatus} = '0;
		tick(20);
		chk("rstStatus", 32'(statusWord), 32'h0);
		sys_rst = 1'b0;
		foreach (rwIdx[k]) begin
			rdx(rwIdx[k], 32'h0, "rwReset");
			v = $urandom;
			wr(rwIdx[k], v);
			rdx(rwIdx[k], (k == 1 || k == 2) ? {16'h0, v[15:0]} : v, "rwBack");
		end
		faultCode = 16'($urandom);
		modeDisplay = 8'($urandom_range(10));
		actualTorque = 16'($urandom_range(10000)) - 16'h1388;
		actualSpeed = $urandom;
		actualPosEnc = $urandom;
		baseStatus = 16'($urandom);
		wr(IDX_FAULT_CODE, 32'hFFFF_FFFF);
		rdx(IDX_FAULT_CODE, {16'h0, faultCode}, "fault");
		rdx(IDX_MODE_DISPLAY, {24'h0, modeDisplay}, "mode");
		rdx(IDX_MEAS_TORQUE, {16'h0, actualTorque}, "torque");
		rdx(IDX_MEAS_SPEED, actualSpeed, "speed");
		rdx(IDX_MEAS_POS_RAW, actualPosEnc, "posRaw");
		rdx(16'h1234, 32'h0, "unmapped");
		chk("base", 32'(statusWord & ~SW_OWN_MASK), 32'(baseStatus & ~SW_OWN_MASK));
		$display("test objects done");
		for (int k = 0; k < 4; k++) begin
			motorMaxSpeed = $urandom;
			v = (k == 0) ? motorMaxSpeed : $urandom;
			wr(IDX_SPEED_CEILING, v);
			objWr = 1'b0;
			tick(2);
			chk("limit", speedLimit, (v < motorMaxSpeed) ? v : motorMaxSpeed);
		end
		$display("test speed done");
		wr(IDX_ARRIVAL_WINDOW, 32'h2);
		wr(IDX_ARRIVAL_DWELL, 32'h2);
		wr(IDX_DEV_LIMIT, 32'h5);
		objWr = 1'b0;
		actualPos = 32'h0000_1000;
		homingDone = 1'b1;
		tick(3);
		chk("homed", 32'(statusWord[SW_HOMED]), 32'h1);
		chk("arrIdle", 32'(posComplete), 32'h0);
		quickStopDone = 1'b1;
		tick(3);
		chk("qstop", 32'(statusWord[SW_ARRIVED]), 32'h1);
		{homingDone, quickStopDone} = '0;
		tick(3);
		chk("unhomed", 32'(statusWord[SW_HOMED]), 32'h0);
		rdx(IDX_STATE_WORD, {16'h0, (baseStatus & ~SW_OWN_MASK) | 16'h2000}, "stWord");
		$display("test status done");
		t = 32'($urandom_range(32'h000F_FFFF)) + 32'h0001_0000;
		n0 = starts;
		sp(t, 1'b0, 1'b0, 1'b0);
		chk("starts", 32'(starts - n0), 32'h1);
		chk("target", lastTgt, t);
		actualPos = t + 32'h2;
		tick(3);
		chk("early", 32'(posComplete), 32'h0);
		tick(20);
		chk("arrived", 32'(statusWord[SW_ARRIVED]), 32'h1);
		actualPos = t + 32'h3;
		tick(2);
		chk("left", 32'(posComplete), 32'h0);
		actualPos = t - 32'h2;
		tick(3);
		chk("restart", 32'(posComplete), 32'h0);
		tick(20);
		chk("again", 32'(posComplete), 32'h1);
		actualPos = t - 32'h5;
		tick(2);
		chk("devEdge", 32'(devAlarm), 32'h0);
		actualPos = t - 32'h6;
		tick(2);
		chk("devOver", 32'(statusWord[SW_FOLLOW_ERR]), 32'h1);
		rdx(IDX_TRACKING_ERR, 32'h6, "trackErr");
		$display("test handshake done");
		actualPos = t;
		tick(20);
		n0 = starts;
		sp(t, 1'b1, 1'b0, 1'b0);
		chk("immStart", 32'(starts - n0), 32'h1);
		chk("cleared", 32'(cplAfter), 32'h0);
		actualPos = 32'h0;
		n0 = starts;
		sp(t + 32'h100, 1'b0, 1'b0, 1'b1);
		chk("queued", 32'(starts - n0), 32'h0);
		sp(t + 32'h200, 1'b0, 1'b0, 1'b1);
		chk("queued2", 32'(starts - n0), 32'h0);
		motionIdle = 1'b1;
		tick(1);
		chk("ackDrop", 32'(statusWord[SW_ACK]), 32'h0);
		tick(1);
		chk("qStart", 32'(starts - n0), 32'h1);
		chk("qTarget", lastTgt, t + 32'h200);
		$display("test queue done");
		motionIdle = 1'b1;
		tick(2);
		v = 32'($urandom_range(32'h0000_FFFF));
		actualPos = 32'h0002_0000;
		sp(v, 1'b1, 1'b1, 1'b0);
		chk("relTarget", lastTgt, v + actualPos);
		$display("test relative done");
		wr(IDX_WINDOW_UNIT, 32'h1);
		objWr = 1'b0;
		actualPos = 32'h0050_0000;
		tick(1);
		demandPosEnc = actualPosEnc + 32'h1;
		tick(24);
		chk("encUnit", 32'(posComplete), 32'h1);
		wr(IDX_WINDOW_UNIT, 32'h0);
		objWr = 1'b0;
		tick(3);
		chk("cmdUnit", 32'(posComplete), 32'h0);
		$display("test units done");
		print_verdict();
	end
endmodule : ppss_setpoint_status_tb_top
